// file: service_test_pkg.sv
// constants and types for the service test and lock sequencer
package service_test_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SUM = 8'h0c;
  localparam logic [7:0] OFF_HOURS = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;

  // control bits, all zero after reset (auto, torr on, unlocked keys)
  localparam int CTRL_ACK_MANUAL = 0;
  localparam int CTRL_UNIT_SUPP = 1;
  localparam int CTRL_ENTRY_LOCK = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // test entry selection codes
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_PROG = 3'h1;
  localparam logic [2:0] SEL_PARAM = 3'h2;
  localparam logic [2:0] SEL_DISP = 3'h3;
  localparam logic [2:0] SEL_RELAY = 3'h4;

  // interrupt status and mask bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SUP = 1;
  localparam int IRQ_HOUR = 2;

  // relay walk: step 0 all off, odd steps one relay on, even steps off
  localparam logic [3:0] RELAY_FIRST_STEP = 4'h1;
  localparam logic [3:0] RELAY_LAST_STEP = 4'he;

  // timing, figures in their own units
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned SUP_ACK_MS = 2000;
  localparam longint unsigned DISP_MS = 10000;
  localparam longint unsigned RELAY_STEP_MS = 1000;
  localparam longint unsigned HOUR_S = 3600;
  localparam longint unsigned SUP_ACK_CYCLES = CLK_HZ * SUP_ACK_MS / 1000;
  localparam longint unsigned DISP_CYCLES = CLK_HZ * DISP_MS / 1000;
  localparam longint unsigned STEP_CYCLES = CLK_HZ * RELAY_STEP_MS / 1000;
  localparam longint unsigned HOUR_CYCLES = CLK_HZ * HOUR_S;

  typedef enum logic [2:0] {
    T_IDLE,
    T_PROG,
    T_PARAM,
    T_DISP,
    T_RELAY,
    T_DONE
  } test_state_t;

endpackage : service_test_pkg

// file: service_test_sequencer.sv
// service test sequencer: lock settings, self tests, hours, registers
`timescale 1ns/1ns
module service_test_sequencer #(
  parameter logic [39:0] ACK_CYCLES = 40'(service_test_pkg::SUP_ACK_CYCLES),
  parameter logic [39:0] DISP_CYCLES = 40'(service_test_pkg::DISP_CYCLES),
  parameter logic [39:0] STEP_CYCLES = 40'(service_test_pkg::STEP_CYCLES),
  parameter logic [39:0] HOUR_CYCLES = 40'(service_test_pkg::HOUR_CYCLES),
  parameter logic [15:0] PROG_WORDS = 16'h0400,
  parameter logic [15:0] PARAM_WORDS = 16'h0100
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic service_key_held,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_ack,
  input wire logic param_change_req,
  output logic param_change_ok,
  output logic torr_selectable,
  input wire logic supervisor_fault,
  output logic supervisor_msg,
  output logic [15:0] mem_addr,
  input wire logic [31:0] prog_rdata,
  input wire logic [31:0] prog_expected,
  input wire logic [31:0] param_rdata,
  input wire logic [31:0] param_expected,
  output logic test_running,
  output logic test_pass,
  output logic test_error,
  output logic [31:0] checksum_value,
  output logic display_all_on,
  output logic [3:0] switch_relays,
  output logic gauge_relay_first,
  output logic gauge_relay_second,
  output logic fault_relay,
  output logic [31:0] operating_time_count
);

  typedef struct packed {
    logic [2:0] ctrl;
    logic [2:0] sel;
    logic [2:0] mask;
    logic [2:0] irq_st;
    logic unlocked;
    logic strap_done;
    service_test_pkg::test_state_t st;
    logic [15:0] addr;
    logic [31:0] sum;
    logic pass;
    logic fail;
    logic [39:0] timer;
    logic [3:0] step;
    logic [6:0] relays;
    logic disp_on;
    logic sup_msg;
    logic [39:0] sup_timer;
    logic [39:0] hour_cyc;
    logic [31:0] hours;
    logic both_prev;
    logic chg_ok;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic manual;
  logic unit_supp;
  logic lock;
  logic start;
  logic leave;
  logic [31:0] status;

  // terminal count of a free counter against its limit
  function automatic logic hit(input logic [39:0] c, input logic [39:0] lim);
    return c == lim - 40'h1;
  endfunction : hit

  // running checksum is a plain 32-bit wrapping sum of words
  function automatic logic [31:0] add(input logic [31:0] a,
                                      input logic [31:0] b);
    return a + b;
  endfunction : add

  // odd steps light one relay, even steps leave all off
  function automatic logic [6:0] pattern(input logic [3:0] step);
    logic [6:0] p;
    p = 7'h0;
    if (step[0]) begin
      p[3'(step >> 1)] = 1'b1;
    end
    return p;
  endfunction : pattern

  assign manual = s.ctrl[service_test_pkg::CTRL_ACK_MANUAL];
  assign unit_supp = s.ctrl[service_test_pkg::CTRL_UNIT_SUPP];
  assign lock = s.ctrl[service_test_pkg::CTRL_ENTRY_LOCK];
  // start only on the edge where both arrows become pressed
  assign start = key_up & key_down & ~s.both_prev & s.unlocked;
  assign leave = wr && addr == service_test_pkg::OFF_SEL;
  assign status = {20'h0, s.step, 2'h0, ~unit_supp, s.sup_msg, s.unlocked,
                   test_running, s.fail, s.pass};

  // outputs straight from state
  assign rdata = s.rdata;
  assign irq = |(s.irq_st & s.mask);
  assign param_change_ok = s.chg_ok;
  assign torr_selectable = ~unit_supp;
  assign supervisor_msg = s.sup_msg;
  assign mem_addr = s.addr;
  assign test_running = s.st != service_test_pkg::T_IDLE &&
                        s.st != service_test_pkg::T_DONE;
  assign test_pass = s.pass;
  assign test_error = s.fail;
  assign checksum_value = s.sum;
  assign display_all_on = s.disp_on;
  // relays one to four, then both gauge relays, then the fault relay
  assign switch_relays = s.relays[3:0];
  assign gauge_relay_first = s.relays[4];
  assign gauge_relay_second = s.relays[5];
  assign fault_relay = s.relays[6];
  assign operating_time_count = s.hours;

  // next state
  always_comb begin
    logic [2:0] ev;
    logic [31:0] word;
    ev = 3'h0;
    word = 32'h0;
    next_s = s;
    next_s.both_prev = key_up & key_down;
    // the key strap is caught on the first clock after reset release
    next_s.strap_done = 1'b1;
    if (!s.strap_done) begin
      next_s.unlocked = service_key_held;
    end
    next_s.chg_ok = param_change_req & ~lock;
    if (wr) begin
      if (addr == service_test_pkg::OFF_CTRL) begin
        next_s.ctrl = wdata[2:0];
      end else if (addr == service_test_pkg::OFF_SEL) begin
        next_s.sel = wdata[2:0];
      end else if (addr == service_test_pkg::OFF_MASK) begin
        next_s.mask = wdata[2:0];
      end
    end
    // test sequencing
    case (s.st)
      service_test_pkg::T_IDLE, service_test_pkg::T_DONE: begin
        if (start) begin
          next_s.addr = 16'h0;
          next_s.sum = 32'h0;
          next_s.pass = 1'b0;
          next_s.fail = 1'b0;
          next_s.timer = 40'h0;
          next_s.step = 4'h0;
          next_s.relays = 7'h0;
          if (s.sel == service_test_pkg::SEL_PROG) begin
            next_s.st = service_test_pkg::T_PROG;
          end else if (s.sel == service_test_pkg::SEL_PARAM) begin
            next_s.st = service_test_pkg::T_PARAM;
          end else if (s.sel == service_test_pkg::SEL_DISP) begin
            next_s.st = service_test_pkg::T_DISP;
            next_s.disp_on = 1'b1;
          end else if (s.sel == service_test_pkg::SEL_RELAY) begin
            next_s.st = service_test_pkg::T_RELAY;
          end
        end
      end
      service_test_pkg::T_PROG, service_test_pkg::T_PARAM: begin
        word = (s.st == service_test_pkg::T_PROG) ? prog_rdata : param_rdata;
        next_s.sum = add(s.sum, word);
        next_s.addr = s.addr + 16'h1;
        if (s.st == service_test_pkg::T_PROG ? s.addr == PROG_WORDS - 16'h1
                                             : s.addr == PARAM_WORDS - 16'h1)
        begin
          // exactly one verdict flag per finished check
          next_s.st = service_test_pkg::T_DONE;
          next_s.pass = add(s.sum, word) ==
            (s.st == service_test_pkg::T_PROG ? prog_expected
                                               : param_expected);
          next_s.fail = ~next_s.pass;
          next_s.addr = 16'h0;
          ev[service_test_pkg::IRQ_DONE] = 1'b1;
        end
      end
      service_test_pkg::T_DISP: begin
        next_s.timer = s.timer + 40'h1;
        if (hit(s.timer, DISP_CYCLES)) begin
          next_s.disp_on = 1'b0;
          next_s.st = service_test_pkg::T_DONE;
          ev[service_test_pkg::IRQ_DONE] = 1'b1;
        end
      end
      service_test_pkg::T_RELAY: begin
        next_s.timer = s.timer + 40'h1;
        if (hit(s.timer, STEP_CYCLES)) begin
          next_s.timer = 40'h0;
          // the all-off opening step is not repeated on later rounds
          next_s.step = (s.step == service_test_pkg::RELAY_LAST_STEP) ?
            service_test_pkg::RELAY_FIRST_STEP : s.step + 4'h1;
          next_s.relays = pattern(next_s.step);
        end
      end
      default: begin
        next_s.st = service_test_pkg::T_IDLE;
      end
    endcase
    // leaving the entry drops the shown result and stops any test
    if (leave) begin
      next_s.st = service_test_pkg::T_IDLE;
      next_s.pass = 1'b0;
      next_s.fail = 1'b0;
      next_s.relays = 7'h0;
      next_s.disp_on = 1'b0;
      next_s.step = 4'h0;
      next_s.addr = 16'h0;
    end
    // supervisor message, a new fault wins over any clear
    if (s.sup_msg) begin
      next_s.sup_timer = s.sup_timer + 40'h1;
      if (manual ? key_ack : hit(s.sup_timer, ACK_CYCLES)) begin
        next_s.sup_msg = 1'b0;
      end
    end
    if (supervisor_fault) begin
      next_s.sup_msg = 1'b1;
      next_s.sup_timer = 40'h0;
      ev[service_test_pkg::IRQ_SUP] = 1'b1;
    end
    // operating time in whole hours
    next_s.hour_cyc = s.hour_cyc + 40'h1;
    if (hit(s.hour_cyc, HOUR_CYCLES)) begin
      next_s.hour_cyc = 40'h0;
      next_s.hours = s.hours + 32'h1;
      ev[service_test_pkg::IRQ_HOUR] = 1'b1;
    end
    // register reads, data stands one cycle only
    next_s.rdata = 32'h0;
    next_s.irq_st = s.irq_st;
    if (rd) begin
      if (addr == service_test_pkg::OFF_CTRL) begin
        next_s.rdata = {29'h0, s.ctrl};
      end else if (addr == service_test_pkg::OFF_SEL) begin
        next_s.rdata = {29'h0, s.sel};
      end else if (addr == service_test_pkg::OFF_STATUS) begin
        next_s.rdata = status;
      end else if (addr == service_test_pkg::OFF_SUM) begin
        next_s.rdata = s.sum;
      end else if (addr == service_test_pkg::OFF_HOURS) begin
        next_s.rdata = s.hours;
      end else if (addr == service_test_pkg::OFF_IRQ) begin
        next_s.rdata = {29'h0, s.irq_st};
        next_s.irq_st = 3'h0;
      end else if (addr == service_test_pkg::OFF_MASK) begin
        next_s.rdata = {29'h0, s.mask};
      end
    end
    // events set after the read clear so none is lost
    next_s.irq_st = next_s.irq_st | ev;
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= service_test_pkg::CTRL_RESET;
      s.sel <= service_test_pkg::SEL_NONE;
      s.st <= service_test_pkg::T_IDLE;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_auto_clear;
    $fell(s.sup_msg) && !$past(manual) |->
      $past(s.sup_timer) == ACK_CYCLES - 40'h1;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto acknowledge cleared at the wrong time");

  property p_manual_hold;
    manual && s.sup_msg && !key_ack |=> s.sup_msg;
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("manual message cleared without acknowledge");

  property p_torr_on;
    !unit_supp |-> torr_selectable;
  endproperty
  a_torr_on: assert property (p_torr_on)
    else $error("torr unit missing while not suppressed");

  property p_torr_off;
    wr && addr == service_test_pkg::OFF_CTRL &&
      wdata[service_test_pkg::CTRL_UNIT_SUPP] |=> !torr_selectable;
  endproperty
  a_torr_off: assert property (p_torr_off)
    else $error("torr unit offered while suppressed");

  property p_lock;
    param_change_req && lock |=> !param_change_ok;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked entry was accepted");

  property p_lock_reset;
    !s.strap_done |-> !lock;
  endproperty
  a_lock_reset: assert property (p_lock_reset)
    else $error("entry lock not off after reset");

  property p_prog_start;
    start && s.sel == service_test_pkg::SEL_PROG && !leave &&
      !test_running |=> s.st == service_test_pkg::T_PROG && test_running;
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("program check did not start");

  property p_prog_end;
    s.st == service_test_pkg::T_PROG ##1 s.st == service_test_pkg::T_DONE
      |-> (test_pass ^ test_error) &&
        checksum_value == $past(s.sum) + $past(prog_rdata);
  endproperty
  a_prog_end: assert property (p_prog_end)
    else $error("program check verdict or checksum wrong");

  property p_param_end;
    $past(s.st) == service_test_pkg::T_PARAM &&
      s.st == service_test_pkg::T_DONE |-> test_pass != test_error;
  endproperty
  a_param_end: assert property (p_param_end)
    else $error("parameter check without single verdict");

  property p_disp_hold;
    $rose(display_all_on) |-> display_all_on [*8];
  endproperty
  a_disp_hold: assert property (p_disp_hold)
    else $error("display test ended early");

  property p_relay_one;
    s.st == service_test_pkg::T_RELAY |->
      $onehot0(s.relays) && s.step <= service_test_pkg::RELAY_LAST_STEP;
  endproperty
  a_relay_one: assert property (p_relay_one)
    else $error("relay walk out of order");

  property p_fault_step;
    fault_relay |-> s.step == service_test_pkg::RELAY_LAST_STEP - 4'h1;
  endproperty
  a_fault_step: assert property (p_fault_step)
    else $error("fault relay on at wrong step");

  property p_hours;
    operating_time_count != $past(operating_time_count) |->
      operating_time_count == $past(operating_time_count) + 32'h1;
  endproperty
  a_hours: assert property (p_hours)
    else $error("hour count jumped");

  property p_unlock;
    !s.unlocked |-> s.st == service_test_pkg::T_IDLE;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("test ran without service key strap");

  property p_result_hold;
    test_pass && !leave && !start |=> test_pass;
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("pass result dropped while entry kept");

endmodule : service_test_sequencer

// file: service_mem_model.sv
// memory model: program and parameter memories on the far side
`timescale 1ns/1ns
module service_mem_model (
  input wire logic [15:0] mem_addr,
  input wire logic corrupt,
  output logic [31:0] prog_rdata,
  output logic [31:0] param_rdata
);
  // combinational answer, since the sequencer samples data in the same cycle
  always_comb begin
    prog_rdata = 32'h1234_0000 | {16'h0000, mem_addr};
    param_rdata = 32'h00a5_0000 | {16'h0000, mem_addr};
    // a stuck bit spoils every parameter word when asked for
    if (corrupt) begin
      param_rdata = param_rdata ^ 32'h0000_0100;
    end
  end
endmodule : service_mem_model

// file: tb_service_test_sequencer.sv
// self-checking bench for the service test sequencer
`timescale 1ns/1ns
module tb_service_test_sequencer;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, prog_rdata, param_rdata;
  logic [31:0] prog_expected = 32'h0, param_expected = 32'h0;
  logic [31:0] checksum_value, operating_time_count, d, h0, exp_sum;
  logic wr = 1'b0, rd = 1'b0, key_up = 1'b0, key_down = 1'b0;
  logic key_ack = 1'b0, param_change_req = 1'b0, corrupt = 1'b0;
  logic supervisor_fault = 1'b0, service_key_held = 1'b0;
  logic irq, param_change_ok, torr_selectable, supervisor_msg;
  logic test_running, test_pass, test_error, display_all_on;
  logic gauge_relay_first, gauge_relay_second, fault_relay;
  logic [3:0] switch_relays;
  logic [6:0] rv, prev;
  logic [15:0] mem_addr;
  int n_mismatch = 0, checked = 0, cnt, idx;

  // short counts keep the run brief; the parameter check keeps its own depth
  service_test_sequencer #(.ACK_CYCLES(40'd20), .DISP_CYCLES(40'd20),
    .STEP_CYCLES(40'd4), .HOUR_CYCLES(40'd50),
    .PROG_WORDS(16'h0004)) dut_u (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .service_key_held(service_key_held), .key_up(key_up),
    .key_down(key_down), .key_ack(key_ack),
    .param_change_req(param_change_req), .param_change_ok(param_change_ok),
    .torr_selectable(torr_selectable), .supervisor_fault(supervisor_fault),
    .supervisor_msg(supervisor_msg), .mem_addr(mem_addr),
    .prog_rdata(prog_rdata), .prog_expected(prog_expected),
    .param_rdata(param_rdata), .param_expected(param_expected),
    .test_running(test_running), .test_pass(test_pass),
    .test_error(test_error), .checksum_value(checksum_value),
    .display_all_on(display_all_on), .switch_relays(switch_relays),
    .gauge_relay_first(gauge_relay_first),
    .gauge_relay_second(gauge_relay_second), .fault_relay(fault_relay),
    .operating_time_count(operating_time_count));

  service_mem_model mem_u (.mem_addr(mem_addr), .corrupt(corrupt),
    .prog_rdata(prog_rdata), .param_rdata(param_rdata));

  // 250 MHz clock
  always #2 clk = ~clk;

  assign rv = {fault_relay, gauge_relay_second, gauge_relay_first,
    switch_relays};

  task automatic close_out;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic key);
    @(posedge clk);
    reset_n <= 1'b0;
    service_key_held <= key;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic press(input logic up, input logic dn);
    @(posedge clk);
    key_up <= up;
    key_down <= dn;
    @(posedge clk);
    key_up <= 1'b0;
    key_down <= 1'b0;
    #1;
  endtask : press

  task automatic pulse_req;
    @(posedge clk);
    param_change_req <= 1'b1;
    @(posedge clk);
    param_change_req <= 1'b0;
    #1;
  endtask : pulse_req

  task automatic fault_pulse;
    @(posedge clk);
    supervisor_fault <= 1'b1;
    @(posedge clk);
    supervisor_fault <= 1'b0;
    #1;
  endtask : fault_pulse

  // bounded wait for the running test to finish
  task automatic wait_idle;
    cnt = 0;
    while (test_running === 1'b1 && cnt < 400) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (test_running !== 1'b0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t test never ended", $time);
      close_out();
    end
  endtask : wait_idle

  function automatic logic [31:0] sum_of(input logic [31:0] base,
                                         input int n);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < n; i++) begin
      s = s + (base | 32'(i));
    end
    return s;
  endfunction : sum_of

  // main sequence
  initial begin
    do_reset(1'b0);
    wr_reg(service_test_pkg::OFF_SEL, 32'h1);
    press(1'b1, 1'b1);
    chk(32'(test_running), 32'h0);
    do_reset(1'b1);
    chk(32'(torr_selectable), 32'h1);
    rd_reg(service_test_pkg::OFF_CTRL, d);
    chk(d, 32'h0);
    rd_reg(8'h1c, d);
    chk(d, 32'h0);
    pulse_req();
    chk(32'(param_change_ok), 32'h1);
    wr_reg(service_test_pkg::OFF_CTRL, 32'h4);
    pulse_req();
    chk(32'(param_change_ok), 32'h0);
    wr_reg(service_test_pkg::OFF_CTRL, 32'h2);
    chk(32'(torr_selectable), 32'h0);
    wr_reg(service_test_pkg::OFF_CTRL, 32'h0);
    chk(32'(torr_selectable), 32'h1);
    // auto acknowledge: message stands for the whole timer only
    fault_pulse();
    cnt = 0;
    repeat (40) begin
      cnt += (supervisor_msg === 1'b1);
      @(posedge clk);
      #1;
    end
    chk(32'(cnt), 32'd20);
    wr_reg(service_test_pkg::OFF_CTRL, 32'h1);
    fault_pulse();
    repeat (40) @(posedge clk);
    #1;
    chk(32'(supervisor_msg), 32'h1);
    @(posedge clk);
    key_ack <= 1'b1;
    @(posedge clk);
    key_ack <= 1'b0;
    #1;
    chk(32'(supervisor_msg), 32'h0);
    wr_reg(service_test_pkg::OFF_CTRL, 32'h0);
    // program check, pass then error
    exp_sum = sum_of(32'h1234_0000, 4);
    prog_expected <= exp_sum;
    wr_reg(service_test_pkg::OFF_SEL, 32'h1);
    press(1'b1, 1'b0);
    chk(32'(test_running), 32'h0);
    press(1'b1, 1'b1);
    chk(32'(test_running), 32'h1);
    @(posedge clk);
    #1;
    chk(32'(mem_addr), 32'h1);
    wait_idle();
    chk({test_pass, test_error}, 32'h2);
    chk(checksum_value, exp_sum);
    rd_reg(service_test_pkg::OFF_SUM, d);
    chk(d, exp_sum);
    repeat (10) @(posedge clk);
    #1;
    chk(32'(test_pass), 32'h1);
    rd_reg(service_test_pkg::OFF_STATUS, d);
    chk(d, 32'h29);
    rd_reg(service_test_pkg::OFF_IRQ, d);
    chk(32'(d[service_test_pkg::IRQ_DONE]), 32'h1);
    prog_expected <= exp_sum ^ 32'h1;
    press(1'b1, 1'b1);
    wait_idle();
    chk({test_pass, test_error}, 32'h1);
    chk(checksum_value, exp_sum);
    wr_reg(service_test_pkg::OFF_SEL, 32'h0);
    chk({test_pass, test_error}, 32'h0);
    // parameter check, clean then with a stuck bit
    param_expected <= sum_of(32'h00a5_0000, 256);
    for (int c = 0; c < 2; c++) begin
      corrupt <= c[0];
      wr_reg(service_test_pkg::OFF_SEL, 32'h2);
      press(1'b1, 1'b1);
      wait_idle();
      chk({test_pass, test_error}, c[0] ? 32'h1 : 32'h2);
    end
    // display test lights everything for the full period
    wr_reg(service_test_pkg::OFF_SEL, 32'h3);
    press(1'b1, 1'b1);
    cnt = 0;
    repeat (40) begin
      cnt += (display_all_on === 1'b1);
      @(posedge clk);
      #1;
    end
    chk(32'(cnt), 32'd20);
    // relay walk: all off, then one relay at a time, wrapping to relay one
    wr_reg(service_test_pkg::OFF_SEL, 32'h4);
    press(1'b1, 1'b1);
    chk(32'(rv), 32'h0);
    prev = 7'h00;
    idx = 0;
    repeat (72) begin
      if (rv !== prev) begin
        chk(32'(rv), idx[0] ? 32'h0 : 32'h1 << ((idx / 2) % 7));
        idx++;
        prev = rv;
      end
      @(posedge clk);
      #1;
    end
    chk(32'(idx >= 15), 32'h1);
    wr_reg(service_test_pkg::OFF_SEL, 32'h0);
    // hour tick raises the unmasked interrupt; a read clears it
    wr_reg(service_test_pkg::OFF_MASK, 32'h4);
    rd_reg(service_test_pkg::OFF_MASK, d);
    chk(d, 32'h4);
    rd_reg(service_test_pkg::OFF_IRQ, d);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 60) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(32'(irq), 32'h1);
    h0 = operating_time_count;
    repeat (50) @(posedge clk);
    #1;
    chk(operating_time_count, h0 + 32'h1);
    rd_reg(service_test_pkg::OFF_IRQ, d);
    chk(32'(d[service_test_pkg::IRQ_HOUR]), 32'h1);
    chk(32'(irq), 32'h0);
    wr_reg(service_test_pkg::OFF_MASK, 32'h0);
    cnt = 0;
    repeat (60) begin
      cnt += (irq === 1'b1);
      @(posedge clk);
      #1;
    end
    chk(32'(cnt), 32'h0);
    close_out();
  end
endmodule : tb_service_test_sequencer
